//--- core/srq_ctrl.v
`timescale 1ns/100ps
`include "srq_defines.vh"

module srq_ctrl (
	input wire clock,
	input wire arst_n,
	input wire link_reset_n,
	input wire global_reset_in_n,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_rvalid,
	input wire serirq_in,
	output wire serirq_out,
	output wire serirq_oe,
	output wire [15:0] irq_line_state,
	output wire stream_busy
);

	// Combined reset: power-on, link and global
	wire rst_n;

	// Register state
	reg [3:0] mode_r;
	reg [15:0] trig_r;
	wire [15:0] stat_w;

	// Stream sequencer state
	reg [3:0] phase_r;
	reg [3:0] phase_nxt;
	reg [3:0] cnt_r;
	reg [3:0] cnt_nxt;
	reg [3:0] slot_r;
	reg [3:0] slot_nxt;
	reg busy_r;

	// Access decode
	wire hit_mode;
	wire hit_stat;
	wire [15:0] stat_clr;
	wire sample_en;

	// Mode fields
	wire quiet_poll_select;
	wire recovery_tristate_select;
	wire [1:0] start_width_code;

	// Start frame length minus one from the width code
	function [3:0] srq_start_len;
		input [1:0] code;
		begin
			if (code == `SRQ_WCODE_6) begin
				srq_start_len = `SRQ_WLEN_6;
			end else if (code == `SRQ_WCODE_8) begin
				srq_start_len = `SRQ_WLEN_8;
			end else begin
				// Reserved code falls back to the shortest frame
				srq_start_len = `SRQ_WLEN_4;
			end
		end
	endfunction

	// Byte-lane merge for configuration writes
	function [7:0] srq_lane;
		input [7:0] old_val;
		input [7:0] new_val;
		input en;
		begin
			if (en) begin
				srq_lane = new_val;
			end else begin
				srq_lane = old_val;
			end
		end
	endfunction

	// Any of the three resets clears the settings
	assign rst_n = arst_n & link_reset_n & global_reset_in_n;

	// Dword decode of the configuration offset
	assign hit_mode = (cfg_addr & `SRQ_DWORD_MASK) == `SRQ_OFF_MODE;
	assign hit_stat = (cfg_addr & `SRQ_DWORD_MASK) == `SRQ_OFF_STAT;

	assign quiet_poll_select = mode_r[`SRQ_MODE_POLL];
	assign recovery_tristate_select = mode_r[`SRQ_MODE_TRI];
	assign start_width_code = mode_r[`SRQ_MODE_WHI:`SRQ_MODE_WLO];

	// Write-one-to-clear mask for the status bits
	assign stat_clr = (cfg_wr && hit_stat) ?
		({{8{cfg_be[1]}}, {8{cfg_be[0]}}} & cfg_wdata[15:0]) :
		`SRQ_STAT_RST;

	// Mode control: only the low nibble is stored
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= `SRQ_MODE_RST;
		end else if (cfg_wr && hit_mode && cfg_be[0]) begin
			mode_r <= cfg_wdata[3:0] & `SRQ_MODE_USED;
		end
	end

	// Trigger select, two byte lanes in the upper half of the dword
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			trig_r <= `SRQ_TRIG_RST;
		end else if (cfg_wr && hit_mode) begin
			trig_r[15:8] <= srq_lane(trig_r[15:8], cfg_wdata[31:24], cfg_be[3]);
			trig_r[7:0] <= srq_lane(trig_r[7:0], cfg_wdata[23:16], cfg_be[2]);
		end
	end

	// Read data registered, one cycle after the read strobe
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata <= 32'h00000000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				if (hit_mode) begin
					cfg_rdata <= {trig_r, 8'h00, 4'h0, mode_r};
				end else if (hit_stat) begin
					cfg_rdata <= {16'h0000, stat_w};
				end else begin
					cfg_rdata <= 32'h00000000;
				end
			end
		end
	end

	// Stream sequencer: start, sixteen slots, stop
	always @* begin
		phase_nxt = phase_r;
		cnt_nxt = cnt_r;
		slot_nxt = slot_r;
		case (phase_r)
			`SRQ_ST_IDLE: begin
				// Quiet mode waits for a peripheral to pull the line low
				if (!quiet_poll_select || !serirq_in) begin
					phase_nxt = `SRQ_ST_START;
					cnt_nxt = srq_start_len(start_width_code);
				end
			end
			`SRQ_ST_START: begin
				if (cnt_r == 4'h0) begin
					phase_nxt = `SRQ_ST_SREC;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			`SRQ_ST_SREC: begin
				phase_nxt = `SRQ_ST_STA;
			end
			`SRQ_ST_STA: begin
				phase_nxt = `SRQ_ST_SMP;
				slot_nxt = 4'h0;
			end
			`SRQ_ST_SMP: begin
				phase_nxt = `SRQ_ST_DREC;
			end
			`SRQ_ST_DREC: begin
				phase_nxt = `SRQ_ST_DTA;
			end
			`SRQ_ST_DTA: begin
				if (slot_r == `SRQ_LAST_SLOT) begin
					phase_nxt = `SRQ_ST_STOP;
					// Stop length tells peripherals the next mode
					if (quiet_poll_select) begin
						cnt_nxt = `SRQ_STOP_QUIET;
					end else begin
						cnt_nxt = `SRQ_STOP_CONT;
					end
				end else begin
					phase_nxt = `SRQ_ST_SMP;
					slot_nxt = slot_r + 4'h1;
				end
			end
			`SRQ_ST_STOP: begin
				if (cnt_r == 4'h0) begin
					phase_nxt = `SRQ_ST_PREC;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			`SRQ_ST_PREC: begin
				phase_nxt = `SRQ_ST_PTA;
			end
			`SRQ_ST_PTA: begin
				// Continuous mode starts the next frame at once
				if (quiet_poll_select) begin
					phase_nxt = `SRQ_ST_IDLE;
				end else begin
					phase_nxt = `SRQ_ST_START;
					cnt_nxt = srq_start_len(start_width_code);
				end
			end
			default: begin
				phase_nxt = `SRQ_ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= `SRQ_ST_IDLE;
			cnt_r <= 4'h0;
			slot_r <= 4'h0;
		end else begin
			phase_r <= phase_nxt;
			cnt_r <= cnt_nxt;
			slot_r <= slot_nxt;
		end
	end

	assign sample_en = (phase_r == `SRQ_ST_SMP);

	// Busy flag registered from the next phase, in step with phase_r
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= (phase_nxt != `SRQ_ST_IDLE);
		end
	end
	assign stream_busy = busy_r;

	// Pin driver for start, stop and recovery
	srq_pin_drive u_pin (
		.clock(clock),
		.rst_n(rst_n),
		.phase_nxt(phase_nxt),
		.recovery_tristate_select(recovery_tristate_select),
		.serirq_out(serirq_out),
		.serirq_oe(serirq_oe)
	);

	// Per-line sampling and level status
	srq_slot_capture u_cap (
		.clock(clock),
		.rst_n(rst_n),
		.sample_en(sample_en),
		.slot(slot_r),
		.line_low(~serirq_in),
		.trigger_select(trig_r),
		.clear_mask(stat_clr),
		.level_seen(stat_w),
		.line_state(irq_line_state)
	);

endmodule

//--- core/srq_defines.vh
`ifndef SRQ_DEFINES_VH
`define SRQ_DEFINES_VH

// Configuration offsets
`define SRQ_OFF_MODE 8'hE0
`define SRQ_OFF_TRIG 8'hE2
`define SRQ_OFF_STAT 8'hE4
`define SRQ_DWORD_MASK 8'hFC

// Reset values
`define SRQ_MODE_RST 4'h0
`define SRQ_TRIG_RST 16'h0000
`define SRQ_STAT_RST 16'h0000

// Mode control field positions
`define SRQ_MODE_TRI 0
`define SRQ_MODE_POLL 1
`define SRQ_MODE_WLO 2
`define SRQ_MODE_WHI 3
`define SRQ_MODE_USED 4'hF

// Start width codes and lengths, minus one
`define SRQ_WCODE_4 2'h0
`define SRQ_WCODE_6 2'h1
`define SRQ_WCODE_8 2'h2
`define SRQ_WLEN_4 4'h3
`define SRQ_WLEN_6 4'h5
`define SRQ_WLEN_8 4'h7

// Stop frame lengths, minus one
`define SRQ_STOP_QUIET 4'h1
`define SRQ_STOP_CONT 4'h2

// Slot numbering
`define SRQ_LAST_SLOT 4'hF

// Stream phases
`define SRQ_ST_IDLE 4'h0
`define SRQ_ST_START 4'h1
`define SRQ_ST_SREC 4'h2
`define SRQ_ST_STA 4'h3
`define SRQ_ST_SMP 4'h4
`define SRQ_ST_DREC 4'h5
`define SRQ_ST_DTA 4'h6
`define SRQ_ST_STOP 4'h7
`define SRQ_ST_PREC 4'h8
`define SRQ_ST_PTA 4'h9

`endif

//--- core/srq_pin_drive.v
`timescale 1ns/100ps
`include "srq_defines.vh"

module srq_pin_drive (
	input wire clock,
	input wire rst_n,
	input wire [3:0] phase_nxt,
	input wire recovery_tristate_select,
	output reg serirq_out,
	output reg serirq_oe
);

	// Pin drive registered from the next stream phase
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			serirq_out <= 1'b1;
			serirq_oe <= 1'b0;
		end else begin
			case (phase_nxt)
				`SRQ_ST_START, `SRQ_ST_STOP: begin
					serirq_out <= 1'b0;
					serirq_oe <= 1'b1;
				end
				`SRQ_ST_SREC, `SRQ_ST_PREC: begin
					serirq_out <= 1'b1;
					serirq_oe <= ~recovery_tristate_select;
				end
				default: begin
					serirq_out <= 1'b1;
					serirq_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule

//--- core/srq_slot_capture.v
`timescale 1ns/100ps
`include "srq_defines.vh"

module srq_slot_capture (
	input wire clock,
	input wire rst_n,
	input wire sample_en,
	input wire [3:0] slot,
	input wire line_low,
	input wire [15:0] trigger_select,
	input wire [15:0] clear_mask,
	output wire [15:0] level_seen,
	output wire [15:0] line_state
);

	genvar i;
	generate
		for (i = 0; i < 16; i = i + 1) begin : g_line
			reg seen_r;
			reg state_r;
			wire hit;
			// Line sampled low in its own slot
			assign hit = sample_en && (slot == i) && line_low;
			// Status: set beats clear, edge lines never set
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					seen_r <= 1'b0;
				end else if (hit && trigger_select[i]) begin
					seen_r <= 1'b1;
				end else if (clear_mask[i]) begin
					seen_r <= 1'b0;
				end
			end
			// Current level of each line from the stream
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					state_r <= 1'b0;
				end else if (sample_en && (slot == i)) begin
					state_r <= line_low;
				end
			end
			assign level_seen[i] = seen_r;
			assign line_state[i] = state_r;
		end
	endgenerate

endmodule

//--- verification/srq_ctrl_assertions.sv
`timescale 1ns/100ps
module srq_ctrl_checker (
	input wire clock,
	input wire arst_n,
	input wire link_reset_n,
	input wire global_reset_in_n,
	input wire [7:0] cfg_addr,
	input wire [3:0] cfg_be,
	input wire cfg_wr,
	input wire [31:0] cfg_wdata,
	input wire [31:0] cfg_rdata,
	input wire cfg_rvalid,
	input wire serirq_out,
	input wire serirq_oe,
	input wire stream_busy
);
	wire rst_all = arst_n & link_reset_n & global_reset_in_n;
	wire host_low = serirq_oe & ~serirq_out;
	reg [3:0] mode_r;
	reg [3:0] mode_d_r;
	reg [3:0] run_r;
	reg [3:0] width_r;
	reg [5:0] pos_r;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_all);
	// Shadow mode bits, low run length and slot position
	always @(posedge clock or negedge rst_all) begin
		if (!rst_all) begin
			mode_r <= 4'h0;
			mode_d_r <= 4'h0;
			run_r <= 4'h0;
			width_r <= 4'h4;
			pos_r <= 6'h00;
		end else begin
			if (cfg_wr && cfg_addr[7:2] == 6'h38 && cfg_be[0])
				mode_r <= cfg_wdata[3:0];
			// Delayed copy matches the mode the design used one edge before its pin changed
			mode_d_r <= mode_r;
			run_r <= host_low ? run_r + 4'h1 : 4'h0;
			if (host_low && run_r == 4'h0)
				width_r <= mode_d_r[3:2] == 2'h1 ? 4'h6 : mode_d_r[3:2] == 2'h2 ? 4'h8 : 4'h4;
			pos_r <= !host_low && run_r > 4'h3 ? 6'h01 : pos_r != 6'h00 && pos_r < 6'h31 ? pos_r + 6'h01 : 6'h00;
		end
	end
	mode_upper_zero_a: assert property (cfg_rvalid && $past(cfg_addr[7:2]) == 6'h38 |-> cfg_rdata[15:4] == 12'h000)
		else $error("mode upper bits not zero");
	start_width_a: assert property ($fell(host_low) && run_r > 4'h3 |-> run_r == width_r)
		else $error("start width wrong");
	recovery_drive_a: assert property ($fell(host_low) |-> serirq_out && serirq_oe == !mode_d_r[0])
		else $error("recovery drive wrong");
	turnaround_float_a: assert property ($fell(host_low) |=> !serirq_oe)
		else $error("turnaround driven");
	slots_released_a: assert property (pos_r != 6'h00 |-> !serirq_oe)
		else $error("line driven in slots");
	stop_length_a: assert property ($fell(host_low) && run_r < 4'h4 |-> run_r == (mode_r[1] ? 4'h2 : 4'h3))
		else $error("stop length wrong");
	continuous_restart_a: assert property ($fell(host_low) && run_r < 4'h4 && !mode_r[1] |-> ##2 host_low)
		else $error("no restart");
	quiet_idle_a: assert property ($fell(host_low) && run_r < 4'h4 && mode_r[1] |-> ##2 !stream_busy)
		else $error("quiet not idle");
endmodule

bind srq_ctrl srq_ctrl_checker u_chk (.clock, .arst_n, .link_reset_n, .global_reset_in_n, .cfg_addr, .cfg_be,
	.cfg_wr, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .serirq_out, .serirq_oe, .stream_busy);

//--- verification/srq_peer.sv
`timescale 1ns/100ps
module srq_peer (
	input wire clock,
	input wire serirq_out,
	input wire serirq_oe,
	input wire [15:0] irq_req,
	input wire wake,
	output wire serirq_in
);
	integer run = 0;
	integer pos = 0;
	reg pull_low = 1'b0;
	// Find end of start frame, pull low in requested sample slots
	always @(posedge clock) begin
		if (serirq_oe && !serirq_out) begin
			run = run + 1;
			pos = 0;
		end else begin
			pos = run > 3 ? 1 : pos > 0 ? pos + 1 : 0;
			run = 0;
		end
		pull_low <= pos > 1 && pos < 48 && (pos - 2) % 3 == 0 && irq_req[(pos - 2) / 3];
	end
	// Wire pulled up when nobody drives it; wake pulls it low to ask for a quiet-mode frame
	assign serirq_in = ~((serirq_oe & ~serirq_out) | pull_low | wake);
endmodule

//--- verification/test_serial_irq_controller.sv
`timescale 1ns/100ps
module test_serial_irq_controller;
	reg clock = 1'b0;
	reg arst_n = 1'b0;
	reg link_reset_n = 1'b1;
	reg global_reset_in_n = 1'b1;
	reg cfg_wr = 1'b0;
	reg cfg_rd = 1'b0;
	reg wake = 1'b0;
	reg [3:0] cfg_be = 4'hF;
	reg [7:0] cfg_addr = 8'h00;
	reg [31:0] cfg_wdata = 32'h0;
	reg [31:0] seed = 32'h9012;
	reg [15:0] req = 16'h0;
	reg [15:0] m_trig = 16'h0;
	reg [15:0] m_stat = 16'h0;
	reg [3:0] m_mode = 4'h0;
	wire [31:0] cfg_rdata;
	wire [15:0] irq_line_state;
	wire cfg_rvalid, serirq_in, serirq_out, serirq_oe, stream_busy;
	integer fails = 0;
	integer checked = 0;
	integer i;
	always #20 clock = ~clock;
	srq_ctrl u_dut (.clock, .arst_n, .link_reset_n, .global_reset_in_n, .cfg_addr, .cfg_be, .cfg_wr, .cfg_rd,
		.cfg_wdata, .cfg_rdata, .cfg_rvalid, .serirq_in, .serirq_out, .serirq_oe, .irq_line_state, .stream_busy);
	srq_peer u_peer (.clock, .serirq_out, .serirq_oe, .irq_req(req), .wake, .serirq_in);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task chk(input [31:0] g, input [31:0] w);
		checked = checked + 1;
		if (g !== w) begin
			fails = fails + 1;
			$display("unexpected at %0t: got %h want %h", $time, g, w);
		end
	endtask
	// Write a full dword and update the model
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clock);
		cfg_addr <= a;
		cfg_wdata <= d;
		cfg_wr <= 1'b1;
		@(posedge clock);
		cfg_wr <= 1'b0;
		if (a == 8'hE0) begin
			m_mode = d[3:0];
			m_trig = d[31:16];
		end
		if (a == 8'hE4)
			m_stat = m_stat & ~d[15:0];
	endtask
	task rd(input [7:0] a, output [31:0] v);
		@(posedge clock);
		cfg_addr <= a;
		cfg_rd <= 1'b1;
		@(posedge clock);
		cfg_rd <= 1'b0;
		@(negedge clock);
		chk({31'h0, cfg_rvalid}, 32'h1);
		v = cfg_rdata;
	endtask
	// Read all windows, unmapped one included
	task regs;
		reg [31:0] v;
		rd(8'hE0, v);
		chk(v, {m_trig, 8'h00, 4'h0, m_mode});
		rd(8'hE4, v);
		chk(v, {16'h0, m_stat});
		rd(8'hE8, v);
		chk(v, 32'h0);
	endtask
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (4000) @(posedge clock);
		fails = fails + 1;
		results;
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		regs;
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			wr(8'hE0, {seed[31:8], seed[7:4], i[1:0], 1'b0, seed[0]});
			req <= seed[15:0] ^ seed[31:16];
			repeat (140) @(posedge clock);
			@(negedge clock);
			chk({16'h0, irq_line_state}, {16'h0, req});
			m_stat = m_stat | (req & m_trig);
			req <= 16'h0;
			repeat (70) @(posedge clock);
			regs;
			wr(8'hE4, seed);
			regs;
		end
		@(posedge clock);
		global_reset_in_n <= 1'b0;
		@(posedge clock);
		global_reset_in_n <= 1'b1;
		m_mode = 4'h0;
		m_trig = 16'h0;
		m_stat = 16'h0;
		regs;
		wr(8'hE0, 32'h2);
		repeat (140) @(posedge clock);
		@(negedge clock);
		chk({31'h0, stream_busy}, 32'h0);
		// Peripheral wakes the quiet stream; one frame runs, then it idles again
		@(posedge clock);
		seed = xs(seed);
		req <= seed[15:0];
		wake <= 1'b1;
		@(posedge clock);
		wake <= 1'b0;
		@(negedge clock);
		chk({31'h0, stream_busy}, 32'h1);
		repeat (70) @(posedge clock);
		@(negedge clock);
		chk({16'h0, irq_line_state}, {16'h0, req});
		chk({31'h0, stream_busy}, 32'h0);
		@(posedge clock);
		link_reset_n <= 1'b0;
		@(posedge clock);
		link_reset_n <= 1'b1;
		m_mode = 4'h0;
		regs;
		results;
	end
endmodule
